// ==== logic/adc_cfg_regs.vh ====
`ifndef ADC_CFG_REGS_VH
`define ADC_CFG_REGS_VH

// register addresses on the 15-bit address phase
`define ADDR_IFCFG_PRI 15'h0000
`define ADDR_IFCFG_SEC 15'h0001
`define ADDR_CH0_GAIN_LO 15'h001c
`define ADDR_CH0_GAIN_HI 15'h001d
`define ADDR_CH1_GAIN_LO 15'h001e
`define ADDR_CH1_GAIN_HI 15'h001f
`define ADDR_MODES 15'h0020
`define ADDR_OSC 15'h0021
`define ADDR_IO 15'h0022
`define ADDR_TPAT0 15'h0023
`define ADDR_TPAT1 15'h0024
`define ADDR_TPAT2 15'h0025
`define ADDR_TPAT3 15'h0026
`define ADDR_DIGITAL_DIAGNOSTICS 15'h0034
`define ADDR_DIGITAL_ERROR_FLAGS 15'h0035

// storage slots of the plain read/write registers
`define IDX_CH0_GAIN_LO 4'h0
`define IDX_CH0_GAIN_HI 4'h1
`define IDX_CH1_GAIN_LO 4'h2
`define IDX_CH1_GAIN_HI 4'h3
`define IDX_MODES 4'h4
`define IDX_OSC 4'h5
`define IDX_IO 4'h6
`define IDX_TPAT0 4'h7
`define IDX_TPAT1 4'h8
`define IDX_TPAT2 4'h9
`define IDX_TPAT3 4'ha
`define IDX_DIGITAL_DIAGNOSTICS 4'hb
`define IDX_DIGITAL_ERROR_FLAGS 4'hc
`define CFG_ENTRIES 13

// reset values
`define IFCFG_PRI_RST 8'h10
`define IFCFG_SEC_RST 8'h00
`define GAIN_LO_RST 8'h00
`define GAIN_HI_RST 8'h80
`define MODES_RST 8'h00
`define OSC_RST 8'h00
`define IO_RST 8'h00
`define TPAT0_RST 8'h0f
`define TPAT1_RST 8'h0f
`define TPAT2_RST 8'h5a
`define TPAT3_RST 8'h5a
`define DIGITAL_DIAGNOSTICS_RST 8'h00
`define DIGITAL_ERROR_FLAGS_RST 8'h00

// field positions
`define SRST_HI_BIT 7
`define SRST_LO_BIT 0
`define ADDR_ORDER_BIT 5
`define DOUT_EN_BIT 4
`define SHORT_INSTR_BIT 3
`define ONE_INSTR_BIT 7
`define STALL_BIT 6
`define RW_BIT 15

// serial framing
`define INSTR_LAST 4'hf
`define BYTE_LAST 4'h7
`define READ_FLAG 1'h1

// synchroniser idle levels {sclk, csN, sdi}
`define PIN_IDLE 3'h2

`endif

// ==== logic/adc_spi_config_register_bank.v ====
// Behaviour
// - soft reset only when bits 7 and 0 are both one in one write
// - soft reset restores every register except the primary interface register
// - address order bit reads 0; streaming address decrements after each byte
// - secondary bit 7: 0 streams decreasing addresses, 1 one instruction each
// - short-instruction bit reads 0; address phase is always 15 bits
// - secondary bit 6 stores writes but never alters transactions
// - writes leave read-only bits unchanged
`timescale 1ns/1ps
`include "adc_cfg_regs.vh"
module adc_spi_config_register_bank (
   // clock and reset
   input wire mclk,
   input wire rst_n,
   // serial pins
   input wire sclk,
   input wire csN,
   input wire sdi,
   output wire sdoOut,
   output wire sdoOe,
   // interface configuration
   output wire oneInstrMode,
   output wire stallSel,
   output wire softResetPulse,
   // configuration for the converter core
   output wire [15:0] ch0Gain,
   output wire [15:0] ch1Gain,
   output wire [7:0] outModes,
   output wire [7:0] oscCtrl,
   output wire [7:0] ioCtrl,
   output wire [31:0] testPattern,
   output wire [7:0] digDiag,
   output wire [7:0] digErr
);
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_INSTR = 2'h1;
   localparam [1:0] ST_DATA = 2'h2;
   localparam [1:0] ST_SKIP = 2'h3;

   // slot order, highest slot first
   localparam [8*`CFG_ENTRIES-1:0] CFG_RST = {
      `DIGITAL_ERROR_FLAGS_RST,
      `DIGITAL_DIAGNOSTICS_RST,
      `TPAT3_RST,
      `TPAT2_RST,
      `TPAT1_RST,
      `TPAT0_RST,
      `IO_RST,
      `OSC_RST,
      `MODES_RST,
      `GAIN_HI_RST,
      `GAIN_LO_RST,
      `GAIN_HI_RST,
      `GAIN_LO_RST
   };
   localparam [7:0] PRI_RST = `IFCFG_PRI_RST;
   localparam [7:0] SEC_RST = `IFCFG_SEC_RST;

   localparam integer B_G0 = (`ADDR_CH0_GAIN_LO - `ADDR_CH0_GAIN_LO) * 8;
   localparam integer B_G1 = (`ADDR_CH1_GAIN_LO - `ADDR_CH0_GAIN_LO) * 8;
   localparam integer B_MODES = (`ADDR_MODES - `ADDR_CH0_GAIN_LO) * 8;
   localparam integer B_OSC = (`ADDR_OSC - `ADDR_CH0_GAIN_LO) * 8;
   localparam integer B_IO = (`ADDR_IO - `ADDR_CH0_GAIN_LO) * 8;
   localparam integer B_TPAT = (`ADDR_TPAT0 - `ADDR_CH0_GAIN_LO) * 8;
   localparam integer B_DIAG = `IDX_DIGITAL_DIAGNOSTICS * 8;
   localparam integer B_ERR = `IDX_DIGITAL_ERROR_FLAGS * 8;

   // pin synchronisers, {sclk, csN, sdi}
   wire [2:0] pinLvl;
   wire [2:0] pinRise;
   wire [2:0] pinFall;
   pin_sync #(
      .W(3),
      .IDLE(`PIN_IDLE)
   ) uSync (
      .mclk(mclk),
      .rst_n(rst_n),
      .din({sclk, csN, sdi}),
      .lvl(pinLvl),
      .rise(pinRise),
      .fall(pinFall)
   );
   wire sdiLvl = pinLvl[0];
   wire csHigh = pinLvl[1];
   wire sclkRise = pinRise[2];
   wire sclkFall = pinFall[2];

   reg [1:0] state_q;
   reg [3:0] bitCnt_q;
   reg [14:0] addr_q;
   reg isRead_q;
   reg oe_q;
   reg oneInstr_q;
   reg stall_q;
   reg srst_q;

   wire [15:0] rxData;
   wire [15:0] rxNext = {rxData[14:0], sdiLvl};
   wire [8*`CFG_ENTRIES-1:0] cfgFlat;

   // slot lookup for the plain read/write registers
   function [4:0] slotOf;
      input [14:0] a;
      begin
         slotOf = 5'h00;
         if (a == `ADDR_CH0_GAIN_LO) begin
            slotOf = {1'b1, `IDX_CH0_GAIN_LO};
         end else if (a == `ADDR_CH0_GAIN_HI) begin
            slotOf = {1'b1, `IDX_CH0_GAIN_HI};
         end else if (a == `ADDR_CH1_GAIN_LO) begin
            slotOf = {1'b1, `IDX_CH1_GAIN_LO};
         end else if (a == `ADDR_CH1_GAIN_HI) begin
            slotOf = {1'b1, `IDX_CH1_GAIN_HI};
         end else if (a == `ADDR_MODES) begin
            slotOf = {1'b1, `IDX_MODES};
         end else if (a == `ADDR_OSC) begin
            slotOf = {1'b1, `IDX_OSC};
         end else if (a == `ADDR_IO) begin
            slotOf = {1'b1, `IDX_IO};
         end else if (a == `ADDR_TPAT0) begin
            slotOf = {1'b1, `IDX_TPAT0};
         end else if (a == `ADDR_TPAT1) begin
            slotOf = {1'b1, `IDX_TPAT1};
         end else if (a == `ADDR_TPAT2) begin
            slotOf = {1'b1, `IDX_TPAT2};
         end else if (a == `ADDR_TPAT3) begin
            slotOf = {1'b1, `IDX_TPAT3};
         end else if (a == `ADDR_DIGITAL_DIAGNOSTICS) begin
            slotOf = {1'b1, `IDX_DIGITAL_DIAGNOSTICS};
         end else if (a == `ADDR_DIGITAL_ERROR_FLAGS) begin
            slotOf = {1'b1, `IDX_DIGITAL_ERROR_FLAGS};
         end
      end
   endfunction

   function [7:0] readReg;
      input [14:0] a;
      reg [4:0] s;
      begin
         s = slotOf(a);
         readReg = 8'h00;
         if (a == `ADDR_IFCFG_PRI) begin
            readReg = PRI_RST;
            // reset bits are never stored, so a later write cannot repeat the reset
            readReg[`SRST_HI_BIT] = PRI_RST[`SRST_HI_BIT];
            readReg[`SRST_LO_BIT] = PRI_RST[`SRST_LO_BIT];
            // only the decrementing order exists
            readReg[`ADDR_ORDER_BIT] = PRI_RST[`ADDR_ORDER_BIT];
            readReg[`DOUT_EN_BIT] = PRI_RST[`DOUT_EN_BIT];
         end else if (a == `ADDR_IFCFG_SEC) begin
            // short-instruction and reserved bits read zero
            readReg = SEC_RST;
            readReg[`SHORT_INSTR_BIT] = SEC_RST[`SHORT_INSTR_BIT];
            readReg[`ONE_INSTR_BIT] = oneInstr_q;
            readReg[`STALL_BIT] = stall_q;
         end else if (s[4]) begin
            readReg = cfgFlat[s[3:0]*8 +: 8];
         end
      end
   endfunction

   wire instrDone = (state_q == ST_INSTR) && sclkRise && (bitCnt_q == `INSTR_LAST);
   wire byteDone = (state_q == ST_DATA) && sclkRise && (bitCnt_q == `BYTE_LAST);
   wire wrEn = byteDone && !isRead_q;
   wire wrPrimary = wrEn && (addr_q == `ADDR_IFCFG_PRI);
   wire wrSecondary = wrEn && (addr_q == `ADDR_IFCFG_SEC);
   wire [4:0] wrSlot = slotOf(addr_q);
   wire [14:0] addrDec = addr_q - 15'h0001;
   wire softRst = wrPrimary && rxNext[`SRST_HI_BIT] && rxNext[`SRST_LO_BIT];
   wire clearCfg = !rst_n || softRst;
   wire txLoad = (instrDone && rxNext[`RW_BIT] == `READ_FLAG) ||
      (byteDone && isRead_q && !oneInstr_q);
   wire [7:0] txData = instrDone ? readReg(rxNext[14:0]) : readReg(addrDec);
   // receive on every filtered rise in the instruction and data phases
   wire rxShift = sclkRise && !csHigh && (state_q == ST_INSTR || state_q == ST_DATA);
   // the first data bit is already on the pin when the data phase opens
   wire txShift = sclkFall && (state_q == ST_DATA) && (bitCnt_q != 4'h0);
   wire txLoadEn = txLoad && !csHigh;

   spi_byte_shift uShift (
      .mclk(mclk),
      .rst_n(rst_n),
      .shiftIn(rxShift),
      .sdiBit(sdiLvl),
      .rxData(rxData),
      .shiftOut(txShift),
      .load(txLoadEn),
      .loadData(txData),
      .txBit(sdoOut)
   );

   // plain read/write registers, one slot each
   genvar i;
   generate
      for (i = 0; i < `CFG_ENTRIES; i = i + 1) begin : gCfg
         reg [7:0] val_q;
         always @(posedge mclk) begin
            if (clearCfg) begin
               val_q <= CFG_RST[i*8 +: 8];
            end else if (wrEn && wrSlot[4] && wrSlot[3:0] == i) begin
               val_q <= rxNext[7:0];
            end
         end
         assign cfgFlat[i*8 +: 8] = val_q;
      end
   endgenerate

   // secondary interface register: only bits 7 and 6 take writes
   always @(posedge mclk) begin
      if (clearCfg) begin
         oneInstr_q <= SEC_RST[`ONE_INSTR_BIT];
         stall_q <= SEC_RST[`STALL_BIT];
      end else if (wrSecondary) begin
         oneInstr_q <= rxNext[`ONE_INSTR_BIT];
         stall_q <= rxNext[`STALL_BIT];
      end
   end

   // one-cycle flag after a soft reset
   always @(posedge mclk) begin
      if (!rst_n) begin
         srst_q <= 1'b0;
      end else begin
         srst_q <= softRst;
      end
   end

   // transaction sequencer
   always @(posedge mclk) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         bitCnt_q <= 4'h0;
         addr_q <= 15'h0000;
         isRead_q <= 1'b0;
         oe_q <= 1'b0;
      end else if (csHigh) begin
         // chip select high aborts the frame; partial bytes are dropped
         state_q <= ST_IDLE;
         bitCnt_q <= 4'h0;
         oe_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               // chip select low opens the instruction phase
               state_q <= ST_INSTR;
               bitCnt_q <= 4'h0;
            end
            ST_INSTR: begin
               if (sclkRise) begin
                  if (bitCnt_q == `INSTR_LAST) begin
                     // full 15-bit address after the direction bit
                     state_q <= ST_DATA;
                     bitCnt_q <= 4'h0;
                     isRead_q <= rxNext[`RW_BIT];
                     addr_q <= rxNext[14:0];
                     oe_q <= rxNext[`RW_BIT] == `READ_FLAG;
                  end else begin
                     bitCnt_q <= bitCnt_q + 4'h1;
                  end
               end
            end
            ST_DATA: begin
               if (sclkRise) begin
                  if (bitCnt_q == `BYTE_LAST) begin
                     bitCnt_q <= 4'h0;
                     if (oneInstr_q) begin
                        state_q <= ST_SKIP;
                        oe_q <= 1'b0;
                     end else begin
                        addr_q <= addrDec;
                     end
                  end else begin
                     bitCnt_q <= bitCnt_q + 4'h1;
                  end
               end
            end
            ST_SKIP: begin
               // later bytes of a single-instruction frame are ignored
               oe_q <= 1'b0;
            end
            default: begin
               oe_q <= 1'b0;
            end
         endcase
      end
   end

   assign sdoOe = oe_q;
   assign oneInstrMode = oneInstr_q;
   assign stallSel = stall_q;
   assign softResetPulse = srst_q;
   assign ch0Gain = cfgFlat[B_G0 +: 16];
   assign ch1Gain = cfgFlat[B_G1 +: 16];
   assign outModes = cfgFlat[B_MODES +: 8];
   assign oscCtrl = cfgFlat[B_OSC +: 8];
   assign ioCtrl = cfgFlat[B_IO +: 8];
   assign testPattern = cfgFlat[B_TPAT +: 32];
   assign digDiag = cfgFlat[B_DIAG +: 8];
   assign digErr = cfgFlat[B_ERR +: 8];
endmodule

// ==== logic/pin_sync.v ====
`timescale 1ns/1ps
module pin_sync #(
   parameter W = 3,
   parameter [W-1:0] IDLE = 0
) (
   // clock and reset
   input wire mclk,
   input wire rst_n,
   // raw pins
   input wire [W-1:0] din,
   // filtered level and edge pulses
   output wire [W-1:0] lvl,
   output wire [W-1:0] rise,
   output wire [W-1:0] fall
);
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : gBit
         reg s1_q;
         reg s2_q;
         reg s3_q;
         reg lvl_q;
         always @(posedge mclk) begin
            if (!rst_n) begin
               s1_q <= IDLE[i];
               s2_q <= IDLE[i];
               s3_q <= IDLE[i];
               lvl_q <= IDLE[i];
            end else begin
               s1_q <= din[i];
               s2_q <= s1_q;
               s3_q <= s2_q;
               // a change counts once the last two stages agree
               if (s2_q == s3_q) begin
                  lvl_q <= s3_q;
               end
            end
         end
         assign lvl[i] = lvl_q;
         assign rise[i] = (s2_q == s3_q) & s3_q & ~lvl_q;
         assign fall[i] = (s2_q == s3_q) & ~s3_q & lvl_q;
      end
   endgenerate
endmodule

// ==== logic/spi_byte_shift.v ====
`timescale 1ns/1ps
module spi_byte_shift (
   // clock and reset
   input wire mclk,
   input wire rst_n,
   // receive side
   input wire shiftIn,
   input wire sdiBit,
   output wire [15:0] rxData,
   // transmit side
   input wire shiftOut,
   input wire load,
   input wire [7:0] loadData,
   output wire txBit
);
   reg [15:0] rx_q;
   reg [7:0] tx_q;

   always @(posedge mclk) begin
      if (!rst_n) begin
         rx_q <= 16'h0000;
      end else if (shiftIn) begin
         rx_q <= {rx_q[14:0], sdiBit};
      end
   end

   // msb first; a load wins over a shift
   always @(posedge mclk) begin
      if (!rst_n) begin
         tx_q <= 8'h00;
      end else if (load) begin
         tx_q <= loadData;
      end else if (shiftOut) begin
         tx_q <= {tx_q[6:0], 1'b0};
      end
   end

   assign rxData = rx_q;
   assign txBit = tx_q[7];
endmodule

// ==== verification/adc_cfg_checker_sva.sv ====
`timescale 1ns/1ps
module adc_cfg_checker (
   // clock and reset
   input wire mclk,
   input wire rst_n,
   // pins
   input wire csN,
   input wire sdoOe,
   // register outputs
   input wire oneInstrMode,
   input wire stallSel,
   input wire softResetPulse,
   input wire [15:0] ch0Gain,
   input wire [7:0] outModes,
   input wire [31:0] testPattern
);
   logic [7:0] csLow_q;
   logic [7:0] csLow_d;
   assign csLow_d = (csN || csLow_q == 8'hff) ? (csN ? 8'h00 : csLow_q) : csLow_q + 8'h01;
   always @(posedge mclk) begin
      csLow_q <= rst_n ? csLow_d : 8'h00;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence frameIdle;
      csN[*6];
   endsequence
   a_oe_frame_end: assert property (frameIdle |-> !sdoOe) else $error("sdo on outside frame");
   a_srst_in_frame: assert property (softResetPulse |-> !csN) else $error("reset outside write");
   a_srst_defaults: assert property (softResetPulse |-> ch0Gain == 16'h8000 && testPattern == 32'h5a5a0f0f
      && outModes == 8'h00 && !oneInstrMode && !stallSel) else $error("reset values wrong");
   a_srst_once: assert property (softResetPulse |=> !softResetPulse[*8]) else $error("reset repeats");
   a_byte_step: assert property (($changed(ch0Gain[15:8]) && $changed(ch0Gain[7:0])) |-> ##[0:2] softResetPulse)
      else $error("two bytes at once");
   a_write_in_frame: assert property ($changed(outModes) |-> !csN) else $error("write outside frame");
   a_stall_in_frame: assert property ($changed(stallSel) |-> !csN) else $error("stall outside frame");
   a_oe_after_instr: assert property ($rose(sdoOe) |-> csLow_q >= 8'h80) else $error("sdo too early");
endmodule

bind adc_spi_config_register_bank adc_cfg_checker chk_u (.mclk(mclk), .rst_n(rst_n), .csN(csN), .sdoOe(sdoOe),
   .oneInstrMode(oneInstrMode), .stallSel(stallSel), .softResetPulse(softResetPulse), .ch0Gain(ch0Gain),
   .outModes(outModes), .testPattern(testPattern));

// ==== verification/spi_host_model.sv ====
`timescale 1ns/1ps
module spi_host_model (
   // clock
   input wire mclk,
   // serial pins
   output logic sclk,
   output logic csN,
   output logic sdi,
   input wire sdoOut,
   input wire sdoOe
);
   logic [7:0] dat [0:3];
   initial begin
      sclk = 1'b0;
      csN = 1'b1;
      sdi = 1'b0;
   end
   task automatic half();
      repeat (6) @(posedge mclk);
   endtask
   task automatic bitx(input logic b, output logic s);
      sdi <= b;
      half();
      sclk <= 1'b1;
      // an undriven data line reads high
      s = sdoOe ? sdoOut : 1'b1;
      half();
      sclk <= 1'b0;
   endtask
   task automatic xfer(input logic rd, input logic [14:0] a, input int n);
      logic s;
      logic [15:0] instr;
      instr = {rd, a};
      csN <= 1'b0;
      half();
      for (int i = 15; i >= 0; i--) bitx(instr[i], s);
      for (int k = 0; k < n; k++) begin
         for (int i = 7; i >= 0; i--) begin
            bitx(dat[k][i], s);
            if (rd) dat[k][i] = s;
         end
      end
      half();
      csN <= 1'b1;
      // a released line must not keep its last level
      sdi <= ~sdi;
      half();
   endtask
endmodule

// ==== verification/test_adc_spi_config_register_bank.sv ====
`timescale 1ns/1ps
module test_adc_spi_config_register_bank;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   int nSrst = 0;
   logic [31:0] rv;
   int n_mismatch = 0;
   int n_compared = 0;
   wire sclk, csN, sdi, sdoOut, sdoOe, oneInstrMode, stallSel, softResetPulse;
   wire [15:0] ch0Gain, ch1Gain;
   wire [7:0] outModes, oscCtrl, ioCtrl, digDiag, digErr;
   wire [31:0] testPattern;
   always #12.5 mclk = ~mclk;
   always @(posedge mclk) begin
      if (softResetPulse === 1'b1) nSrst <= nSrst + 1;
   end
   adc_spi_config_register_bank dut_u (.mclk(mclk), .rst_n(rst_n), .sclk(sclk), .csN(csN), .sdi(sdi),
      .sdoOut(sdoOut), .sdoOe(sdoOe), .oneInstrMode(oneInstrMode), .stallSel(stallSel),
      .softResetPulse(softResetPulse), .ch0Gain(ch0Gain), .ch1Gain(ch1Gain), .outModes(outModes),
      .oscCtrl(oscCtrl), .ioCtrl(ioCtrl), .testPattern(testPattern), .digDiag(digDiag), .digErr(digErr));
   spi_host_model host_u (.mclk(mclk), .sclk(sclk), .csN(csN), .sdi(sdi), .sdoOut(sdoOut), .sdoOe(sdoOe));
   task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [14:0] a, input int n, input logic [31:0] v);
      for (int k = 0; k < n; k++) host_u.dat[k] = v[8*(n-1-k) +: 8];
      host_u.xfer(1'b0, a, n);
   endtask
   task automatic rd(input logic [14:0] a, input int n, output logic [31:0] v);
      host_u.xfer(1'b1, a, n);
      v = 32'h0;
      for (int k = 0; k < n; k++) v = {v[23:0], host_u.dat[k]};
   endtask
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge mclk);
      n_mismatch++;
      results();
   end
   initial begin
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      chk("reset", {ch0Gain, ch1Gain, testPattern, outModes, oscCtrl, ioCtrl, digDiag, digErr, oneInstrMode,
         stallSel, sdoOe}, {16'h8000, 16'h8000, 32'h5a5a0f0f, 40'h0, 3'h0});
      rd(15'h0000, 1, rv);
      chk("primary", rv, 32'h10);
      rd(15'h0001, 1, rv);
      chk("secondary", rv, 32'h0);
      rd(15'h7fff, 1, rv);
      chk("unmapped", rv, 32'h0);
      wr(15'h001d, 2, 32'h1234);
      chk("gain", ch0Gain, 16'h1234);
      wr(15'h0026, 4, 32'h89abcdef);
      chk("pattern", testPattern, 32'h89abcdef);
      rd(15'h0026, 4, rv);
      chk("pattern read", rv, 32'h89abcdef);
      wr(15'h0000, 1, 32'h80);
      wr(15'h0000, 1, 32'h01);
      wr(15'h0000, 1, 32'h7e);
      chk("half reset", {nSrst, ch0Gain}, {32'h0, 16'h1234});
      rd(15'h0000, 1, rv);
      chk("primary fixed", rv, 32'h10);
      wr(15'h0001, 1, 32'h4f);
      rd(15'h0001, 1, rv);
      chk("secondary bits", {rv, stallSel}, {32'h40, 1'b1});
      wr(15'h0021, 2, 32'h5566);
      chk("stall stream", {oscCtrl, outModes}, 16'h5566);
      wr(15'h0000, 1, 32'h81);
      chk("soft reset", {nSrst, ch0Gain, oscCtrl, stallSel}, {32'h1, 16'h8000, 8'h00, 1'b0});
      rd(15'h0000, 1, rv);
      chk("reset bits", rv, 32'h10);
      wr(15'h0000, 1, 32'h80);
      chk("no repeat", nSrst, 32'h1);
      wr(15'h0001, 1, 32'h80);
      wr(15'h0035, 2, 32'haabb);
      chk("one instr", {oneInstrMode, digErr, digDiag}, {1'b1, 8'haa, 8'h00});
      rd(15'h0035, 2, rv);
      chk("one instr read", rv, 32'haaff);
      results();
   end
endmodule
